// file: stp_params.svh
// Constants of the serial test port: register byte addresses, key values,
// control field positions and reset values. Included by the design file and the bench.
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

// Register byte addresses on the APB
`define STP_ADDR_KEY_FIRST 32'hffff0880
`define STP_ADDR_CONTROL 32'hffff0884
`define STP_ADDR_KEY_SECOND 32'hffff0888
`define STP_ADDR_BYTES_ONE_TWO 32'hffff088c
`define STP_ADDR_BYTES_THREE_FOUR 32'hffff0890
`define STP_ADDR_BYTES_FIVE_SIX 32'hffff0894

// Unlock key values
`define STP_KEY_FIRST_VAL 16'h0007
`define STP_KEY_SECOND_VAL 16'h00b9

// Control register fields
`define STP_CTL_EN_BIT 0
`define STP_CTL_RST_BIT 1
`define STP_CTL_LEN_LSB 2
`define STP_CTL_LEN_MSB 4
`define STP_CTL_STATE_LSB 5
`define STP_CTL_STATE_MSB 8
`define STP_CTL_RESET 16'h0000
`define STP_DATA_RESET 16'h0000

// Burst length: code 101 is six bytes, higher codes clamp to it
`define STP_LEN_MAX 3'h5

// Packet layout: start, 8 data, parity, 2 stops
`define STP_PACKET_BITS 4'hc
`define STP_PARITY_POS 4'h9

// State field codes outside the shifting phase
`define STP_CODE_WAIT 4'hd
`define STP_CODE_QUEUED 4'he
`define STP_CODE_IDLE 4'h0

`endif

// file: stp_pkg.sv
// Types of the serial test port: unlock sequence, shifter phase and state record.
// Assumes nothing of its surroundings.
package stp_pkg;

   // Progress through the two-key protected control write
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_ARMED,
      KEY_PENDING
   } stp_key_t;

   // Shifter phase
   typedef enum logic [1:0] {
      TX_IDLE,
      TX_WAIT,
      TX_SEND
   } stp_tx_t;

   // Whole state of the top module
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      stp_key_t key;
      logic [15:0] ctl_pend;
      logic en;
      logic [2:0] len;
      logic [2:0][15:0] dat;
      logic [2:0] loaded;
      logic loading;
      logic [2:0] idx;
      stp_tx_t tx;
      logic [3:0] cnt;
      logic [10:0] sh;
      logic [7:0] byt;
      logic pin;
   } stp_state_t;

endpackage

// file: stp_serial_test_transmitter.sv
// Serial test port: APB register file, two-key protected control, a byte FIFO
// and a one-pin transmitter sending 12-bit packets at the baud timer rate.
// Assumes an APB3 master on pclk and a one-cycle baud_tick pulse per timer overflow.
//
// Functional notes
// - Each burst sends one to six bytes, each in its own 12-bit packet.
// - Packet is start bit, eight data bits, parity bit, two stop bits.
// - One bit time advances per baud timer overflow pulse.
// - Missing or wrong second key, or any other write before it, discards the pending control write.
// - First data register sends low byte first, high byte second.
// - Second data register sends low byte third, high byte fourth.
// - Third data register sends low byte fifth, high byte sixth.
// - Enabled port with loaded data registers starts sending without further command.
// - Control bits 4:2 give length, 000 is one byte up to 101 six.
// - Control bit 1 resets the port; control then reads all zeros.
// - Control bit 0 enables the port.
// - Control bits 8:5 read nonzero while sending, zero when idle.
//
// The implementer's own choice: register access over APB.
`include "stp_params.svh"

// Byte FIFO between the burst loader and the shifter
module stp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } stp_fifo_state_t;

   stp_fifo_state_t s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // Pointer arithmetic needs a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("stp_fifo: DEPTH must be a power of two, at least 2");
   end

   // Full when pointers differ only in the wrap bit
   assign in_ready = (s_q.wp ^ s_q.rp) != {1'b1, {AW{1'b0}}};
   assign out_valid = s_q.wp != s_q.rp;
   assign out_data = mem[s_q.rp[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next pointers; flush drops everything queued
   always_comb
   begin
      s_d = s_q;
      if (push)
         s_d.wp = s_q.wp + 1'b1;
      if (pop)
         s_d.rp = s_q.rp + 1'b1;
      if (flush)
         s_d = '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Storage carries no reset; only pointers decide what is valid
   always_ff @(posedge clk)
   begin
      if (push && !flush)
         mem[s_q.wp[AW-1:0]] <= in_data;
   end
endmodule // stp_fifo

module stp_serial_test_transmitter #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Baud timer overflow pulse
   input wire logic baud_tick,
   // Serial test pin
   output logic tx_pin
);
   if (FIFO_DEPTH < 2)
   begin : g_bad_fifo
      $error("stp_serial_test_transmitter: FIFO_DEPTH must be at least 2");
   end

   stp_pkg::stp_state_t s_q, s_d;
   logic acc, wr, commit, port_rst, start, fifo_flush;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data, push_byte;
   logic [3:0] state_code;

   // Last byte index of a burst, codes above 101 clamp to six bytes
   function automatic logic [2:0] stp_last(input logic [2:0] len);
      stp_last = (len > `STP_LEN_MAX) ? `STP_LEN_MAX : len;
   endfunction

   // Data registers that must be written before a burst of this length
   function automatic logic [2:0] stp_need(input logic [2:0] len);
      stp_need = (len >= 3'h4) ? 3'b111 : (len >= 3'h2) ? 3'b011 : 3'b001;
   endfunction

   // Byte n of the burst: low byte of a register goes before its high byte
   function automatic logic [7:0] stp_pick(input logic [2:0][15:0] dat, input logic [2:0] idx);
      stp_pick = idx[0] ? dat[idx[2:1]][15:8] : dat[idx[2:1]][7:0];
   endfunction

   // Data register slot of a byte address
   function automatic logic [1:0] stp_slot(input logic [31:0] a);
      stp_slot = 2'((a - `STP_ADDR_BYTES_ONE_TWO) >> 2);
   endfunction

   // Access completes at the edge that samples pready high
   assign acc = psel && penable && s_q.pready;
   assign wr = acc && pwrite;
   assign commit = wr && paddr == `STP_ADDR_KEY_SECOND && s_q.key == stp_pkg::KEY_PENDING
                   && pwdata[15:0] == `STP_KEY_SECOND_VAL;
   assign port_rst = commit && pwdata[15:0] == `STP_KEY_SECOND_VAL && s_q.ctl_pend[`STP_CTL_RST_BIT];
   assign fifo_flush = port_rst;
   assign start = s_q.en && !s_q.loading && (s_q.loaded & stp_need(s_q.len)) == stp_need(s_q.len);
   assign push_byte = stp_pick(s_q.dat, s_q.idx);
   assign fifo_pop = fifo_out_valid && s_q.tx == stp_pkg::TX_IDLE && !port_rst;

   // Nonzero while any part of a burst is in flight
   assign state_code = (s_q.tx == stp_pkg::TX_SEND) ? s_q.cnt
                       : (s_q.tx == stp_pkg::TX_WAIT) ? `STP_CODE_WAIT
                       : (s_q.loading || fifo_out_valid) ? `STP_CODE_QUEUED : `STP_CODE_IDLE;

   stp_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .flush(fifo_flush),
      .in_valid(s_q.loading),
      .in_ready(fifo_in_ready),
      .in_data(push_byte),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // Bus, unlock sequence, burst loader and shifter
   always_comb
   begin
      s_d = s_q;
      // One wait state: pready rises in the second access cycle
      s_d.pready = psel && penable && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (psel && penable && !s_q.pready)
      begin
         case (paddr)
            `STP_ADDR_CONTROL:
               s_d.prdata = {23'h0, state_code, s_q.len, 1'b0, s_q.en};
            `STP_ADDR_BYTES_ONE_TWO, `STP_ADDR_BYTES_THREE_FOUR, `STP_ADDR_BYTES_FIVE_SIX:
               s_d.prdata = {16'h0, s_q.dat[stp_slot(paddr)]};
            `STP_ADDR_KEY_FIRST, `STP_ADDR_KEY_SECOND:
               s_d.prdata = '0;
            default:
               s_d.pslverr = 1'b1;
         endcase
      end

      // Loaded flags: a software write in the start cycle survives the clear
      if (start)
         s_d.loaded = '0;
      if (wr)
      begin
         // Any write other than the next key step breaks the sequence
         s_d.key = stp_pkg::KEY_IDLE;
         case (paddr)
            `STP_ADDR_KEY_FIRST:
               if (pwdata[15:0] == `STP_KEY_FIRST_VAL)
                  s_d.key = stp_pkg::KEY_ARMED;
            `STP_ADDR_CONTROL:
               if (s_q.key == stp_pkg::KEY_ARMED)
               begin
                  s_d.ctl_pend = pwdata[15:0];
                  s_d.key = stp_pkg::KEY_PENDING;
               end
            `STP_ADDR_KEY_SECOND:
               if (commit)
               begin
                  s_d.en = s_q.ctl_pend[`STP_CTL_EN_BIT];
                  s_d.len = s_q.ctl_pend[`STP_CTL_LEN_MSB:`STP_CTL_LEN_LSB];
               end
            `STP_ADDR_BYTES_ONE_TWO, `STP_ADDR_BYTES_THREE_FOUR, `STP_ADDR_BYTES_FIVE_SIX:
            begin
               s_d.dat[stp_slot(paddr)] = pwdata[15:0];
               s_d.loaded[stp_slot(paddr)] = 1'b1;
            end
            default:
               s_d.key = stp_pkg::KEY_IDLE;
         endcase
      end

      // Loader queues the burst; FIFO back-pressure holds it
      if (start)
      begin
         s_d.loading = 1'b1;
         s_d.idx = 3'h0;
      end
      else if (s_q.loading && fifo_in_ready)
      begin
         s_d.idx = s_q.idx + 3'h1;
         if (s_q.idx == stp_last(s_q.len))
            s_d.loading = 1'b0;
      end

      // Shifter: every bit lasts exactly one baud tick period
      case (s_q.tx)
         stp_pkg::TX_IDLE:
         begin
            s_d.pin = 1'b1;
            if (fifo_pop)
            begin
               s_d.byt = fifo_out_data;
               s_d.sh = {2'b11, ^fifo_out_data, fifo_out_data};
               s_d.tx = stp_pkg::TX_WAIT;
            end
         end
         stp_pkg::TX_WAIT:
            if (baud_tick)
            begin
               s_d.pin = 1'b0;
               s_d.cnt = 4'h1;
               s_d.tx = stp_pkg::TX_SEND;
            end
         stp_pkg::TX_SEND:
            if (baud_tick)
            begin
               if (s_q.cnt == `STP_PACKET_BITS)
               begin
                  s_d.pin = 1'b1;
                  s_d.cnt = 4'h0;
                  s_d.tx = stp_pkg::TX_IDLE;
               end
               else
               begin
                  s_d.pin = s_q.sh[0];
                  s_d.sh = {1'b1, s_q.sh[10:1]};
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
         default:
            s_d.tx = stp_pkg::TX_IDLE;
      endcase

      // Port reset aborts everything and clears the control fields
      if (port_rst)
      begin
         s_d.en = 1'b0;
         s_d.len = 3'h0;
         s_d.loaded = '0;
         s_d.loading = 1'b0;
         s_d.tx = stp_pkg::TX_IDLE;
         s_d.cnt = 4'h0;
         s_d.pin = 1'b1;
      end
   end

   // State register; pin resets high so the line shows idle at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.pin <= 1'b1;
         s_q.dat <= {3{`STP_DATA_RESET}};
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign tx_pin = s_q.pin;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence armed_ctl_write;
      wr && paddr == `STP_ADDR_CONTROL && s_q.key == stp_pkg::KEY_ARMED;
   endsequence

   sequence bad_second_key;
      s_q.key == stp_pkg::KEY_PENDING && wr
      && !(paddr == `STP_ADDR_KEY_SECOND && pwdata[15:0] == `STP_KEY_SECOND_VAL);
   endsequence

   chk_idle_line_high: assert property (s_q.tx == stp_pkg::TX_IDLE |-> tx_pin)
      else $error("pin not high while shifter idle");
   chk_start_bit_low: assert property (s_q.tx == stp_pkg::TX_WAIT && baud_tick && !port_rst
      |=> !tx_pin && s_q.cnt == 4'h1)
      else $error("start bit not driven low");
   chk_bit_holds: assert property (s_q.tx == stp_pkg::TX_SEND && !baud_tick && !port_rst
      |=> $stable(tx_pin))
      else $error("pin moved without a baud tick");
   chk_parity_even: assert property (s_q.tx == stp_pkg::TX_SEND && s_q.cnt == `STP_PARITY_POS && baud_tick
      && !port_rst |=> tx_pin == ^s_q.byt)
      else $error("parity bit not even parity");
   chk_stop_bits_high: assert property (s_q.tx == stp_pkg::TX_SEND && s_q.cnt > 4'ha |-> tx_pin)
      else $error("stop bit not high");
   chk_packet_length: assert property (s_q.tx == stp_pkg::TX_SEND |-> s_q.cnt >= 4'h1 && s_q.cnt <= 4'hc)
      else $error("packet bit count out of range");
   chk_unkeyed_ignored: assert property (wr && paddr == `STP_ADDR_CONTROL && s_q.key != stp_pkg::KEY_ARMED
      |=> s_q.key == stp_pkg::KEY_IDLE ##1 $stable(s_q.en))
      else $error("control write accepted without first key");
   chk_ctl_pending: assert property (armed_ctl_write |=> s_q.key == stp_pkg::KEY_PENDING)
      else $error("keyed control write not held pending");
   chk_bad_key_drops: assert property (bad_second_key |=> $stable(s_q.en) && $stable(s_q.len))
      else $error("control changed without second key");
   chk_reset_clears: assert property (port_rst |=> s_q.en == 1'b0 && s_q.len == 3'h0 && tx_pin
      ##2 (state_code == 4'h0 || s_q.loading))
      else $error("port reset did not clear control");
   chk_busy_nonzero: assert property (s_q.tx != stp_pkg::TX_IDLE || s_q.loading |-> state_code != 4'h0)
      else $error("state field zero while sending");
   chk_auto_start: assert property (start && !port_rst |=> s_q.loading && s_q.idx == 3'h0)
      else $error("burst did not start");
   chk_disabled_quiet: assert property (!s_q.en |-> !start)
      else $error("burst started while disabled");
   chk_byte_order: assert property (s_q.loading && s_q.idx == 3'h3 |-> push_byte == s_q.dat[1][15:8])
      else $error("fourth byte not from high half of second register");
   chk_burst_length: assert property (s_q.loading && fifo_in_ready && !port_rst && !start
      && s_q.idx == stp_last(s_q.len) |=> !s_q.loading)
      else $error("burst length does not match control code");
endmodule // stp_serial_test_transmitter

// file: stp_rx_model.sv
// Behavioural receiver that stands in for the test equipment on the serial pin.
// Assumes the bench's baud pulse and samples the pin once on each pulse.
module stp_rx_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bit timing and serial line
   input wire logic baud_tick,
   input wire logic tx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   int errs = 0;
   int n = 0;
   logic [10:0] sh;

   // Sample at the pulse that closes each bit time, so every bit must stand a full period
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         n = 0;
      else if (baud_tick)
      begin
         if (n == 0)
         begin
            if (tx_pin === 1'b0)
               n = 1;
         end
         else
         begin
            sh[n-1] = tx_pin;
            n++;
            if (n == 12)
            begin
               if ((^sh[8:0]) !== 1'b0 || sh[10:9] !== 2'b11)
                  errs++;
               q.push_back(sh[7:0]);
               n = 0;
            end
         end
      end
   end
endmodule // stp_rx_model

// file: stp_serial_test_transmitter_tb_top.sv
// Self-checking bench for the serial test port: APB master, baud pulse and receiver.
// Assumes the design's register map header and a baud pulse every four clocks.
`include "stp_params.svh"

module stp_serial_test_transmitter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, baud_tick, pready, pslverr, tx_pin, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [1:0] div;
   logic [15:0] dat[3];
   int fails, n_compared;

   stp_serial_test_transmitter #(.FIFO_DEPTH(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick), .tx_pin(tx_pin));
   stp_rx_model i_rx (.pclk(pclk), .presetn(presetn), .baud_tick(baud_tick), .tx_pin(tx_pin));

   // Clock of 40 ns period
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Baud pulse: one cycle in four, short so bursts stay quick
   always @(posedge pclk)
   begin
      div <= div + 2'h1;
      baud_tick <= (div == 2'h3);
   end

   task automatic summarize();
      $display("errors %0d compared %0d", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (i >= 50)
         fails++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Protected control update through both keys
   task automatic ctl_wr(input logic [15:0] v);
      apb(1'b1, `STP_ADDR_KEY_FIRST, 32'h0007);
      apb(1'b1, `STP_ADDR_CONTROL, {16'h0, v});
      apb(1'b1, `STP_ADDR_KEY_SECOND, 32'h00b9);
   endtask

   // Poll the state field until the port is idle
   task automatic wait_idle();
      int i;
      i = 0;
      do
      begin
         apb(1'b0, `STP_ADDR_CONTROL, 32'h0);
         i++;
      end
      while (rd[8:5] !== 4'h0 && i < 400);
      if (i >= 400)
         fails++;
   endtask

   task automatic t_reset_vals();
      rdchk(`STP_ADDR_CONTROL, 32'h0);
      rdchk(`STP_ADDR_BYTES_ONE_TWO, 32'h0);
      rdchk(`STP_ADDR_BYTES_THREE_FOUR, 32'h0);
      rdchk(`STP_ADDR_BYTES_FIVE_SIX, 32'h0);
      rdchk(`STP_ADDR_KEY_FIRST, 32'h0);
      chk({31'h0, er}, 32'h0);
      rdchk(32'hffff0898, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask

   // Broken key sequences must leave control untouched
   task automatic t_locks();
      apb(1'b1, `STP_ADDR_CONTROL, 32'h0001);
      rdchk(`STP_ADDR_CONTROL, 32'h0);
      apb(1'b1, `STP_ADDR_KEY_FIRST, 32'h0006);
      apb(1'b1, `STP_ADDR_CONTROL, 32'h0001);
      apb(1'b1, `STP_ADDR_KEY_SECOND, 32'h00b9);
      rdchk(`STP_ADDR_CONTROL, 32'h0);
      apb(1'b1, `STP_ADDR_KEY_FIRST, 32'h0007);
      apb(1'b1, `STP_ADDR_CONTROL, 32'h0001);
      apb(1'b1, `STP_ADDR_KEY_SECOND, 32'h00b8);
      rdchk(`STP_ADDR_CONTROL, 32'h0);
      // An unmapped write between control and second key breaks the sequence
      apb(1'b1, `STP_ADDR_KEY_FIRST, 32'h0007);
      apb(1'b1, `STP_ADDR_CONTROL, 32'h0001);
      apb(1'b1, 32'hffff0898, 32'h0);
      apb(1'b1, `STP_ADDR_KEY_SECOND, 32'h00b9);
      rdchk(`STP_ADDR_CONTROL, 32'h0);
   endtask

   // Every length code, bytes in register order, low byte first
   task automatic t_bursts();
      logic [15:0] c;
      int m;
      for (int k = 0; k < 8; k++)
      begin
         m = (k > 5) ? 5 : k; // Codes above 101 act as six bytes
         c = {11'h0, 3'(k), 2'b01};
         ctl_wr(c);
         for (int j = 0; j <= m / 2; j++)
         begin
            dat[j] = 16'(16'h81a5 ^ (k * 16'h2b17) ^ (j * 16'h4c93));
            apb(1'b1, `STP_ADDR_BYTES_ONE_TWO + 32'(4 * j), {16'h0, dat[j]});
         end
         apb(1'b0, `STP_ADDR_CONTROL, 32'h0);
         chk({31'h0, |rd[8:5]}, 32'h1);
         wait_idle();
         chk(i_rx.q.size(), m + 1);
         for (int n = 0; n <= m && n < i_rx.q.size(); n++)
            chk({24'h0, i_rx.q[n]}, {24'h0, dat[n / 2][8 * (n % 2) +: 8]});
         chk({16'h0, rd[15:0]}, {16'h0, c});
         chk(i_rx.errs, 0);
         i_rx.q.delete();
      end
   endtask

   // Port reset in mid-burst, then disabled and re-enabled
   task automatic t_port_reset();
      ctl_wr(16'h0015);
      for (int j = 0; j < 3; j++)
         apb(1'b1, `STP_ADDR_BYTES_ONE_TWO + 32'(4 * j), 32'h0000_6e3c);
      repeat (40) @(posedge pclk);
      ctl_wr(16'h0002);
      wait_idle();
      chk(rd, 32'h0);
      repeat (60) @(posedge pclk);
      chk({31'h0, tx_pin}, 32'h1);
      i_rx.q.delete();
      i_rx.errs = 0;
      apb(1'b1, `STP_ADDR_BYTES_ONE_TWO, 32'h0000_00c3);
      repeat (200) @(posedge pclk);
      chk(i_rx.q.size(), 0);
      ctl_wr(16'h0001);
      wait_idle();
      chk(i_rx.q.size(), 1);
      chk({24'h0, i_rx.q[0]}, 32'h0000_00c3);
   endtask

   // Main sequence
   initial
   begin
      fails = 0;
      n_compared = 0;
      div = 2'h0;
      baud_tick = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals();
      t_locks();
      t_bursts();
      t_port_reset();
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #2000000;
      fails++;
      summarize();
   end
endmodule // stp_serial_test_transmitter_tb_top
